// [shared/sram_defines.svh]
// Purpose: shared constants of the pipelined burst SRAM model
// Assumes: included by the package and by every design module
// Notes: definitions only
`ifndef SRAM_DEFINES_SVH
`define SRAM_DEFINES_SVH

// ==================================================
// geometry
`define ADDR_W 18
`define HI_W 16
`define DATA_W 18
`define LANE_W 9
`define LANES 2
`define DEPTH 262144
`define BURST_W 2

// ==================================================
// encodings and reset values
`define ORDER_LINEAR 1'b0
`define ORDER_RESET 1'b1
`define LANES_ALL 2'h3
`define LANES_NONE 2'h0
`define STEP_ONE 2'h1
`define HI_RESET 16'h0000
`define BURST_RESET 2'h0
`define DATA_RESET 18'h00000
`define ADDR_RESET 18'h00000

// ==================================================
// sleep timing, in clock cycles
`define SLEEP_ENTRY_CYCLES 2
`define SLEEP_EXIT_CYCLES 2

`endif

// [shared/sram_pkg.sv]
// Purpose: types shared by the burst SRAM core and its array
// Assumes: sram_defines.svh supplies all widths
// Notes: one-hot access states
`include "sram_defines.svh"

package sram_pkg;

  // ==================================================
  // pin groups
  typedef struct packed {
    logic processor_address_strobe_n;
    logic controller_address_strobe_n;
    logic burst_step_n;
    logic global_write_n;
    logic byte_write_enable_n;
    logic [`LANES-1:0] byte_lane_select_n;
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic output_gate_n;
    logic sleep_request;
    logic burst_order;
  } sram_ctrl_t;

  typedef struct packed {
    logic [`LANES-1:0] be;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } mem_wr_t;

  // ==================================================
  // access state
  typedef enum logic [3:0] {
    ST_DESEL = 4'h1,
    ST_READ = 4'h2,
    ST_WRITE = 4'h4,
    ST_SLEEP = 4'h8
  } access_e_t;

  typedef struct packed {
    access_e_t mode;
    logic [`HI_W-1:0] addr_hi;
    logic [`BURST_W-1:0] cnt;
    logic [`BURST_W-1:0] base;
    logic [`BURST_W-1:0] step;
    logic order;
    logic sleep_meta;
    logic sleep_sync;
    logic oe;
    logic fresh;
    mem_wr_t wr;
  } core_state_t;

endpackage

// [core/sram_word_array.sv]
// Purpose: 18-bit word store with two byte lanes
// Assumes: one write and one read port, same clock
// Notes: read data registered; a write lands at the clock edge
`include "sram_defines.svh"

module sram_word_array (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] rd_addr,
  input wire sram_pkg::mem_wr_t wr,
  output logic [`DATA_W-1:0] rd_data
);
  import sram_pkg::*;

  logic [`DATA_W-1:0] mem [`DEPTH];
  logic [`DATA_W-1:0] rd_d;
  logic [`DATA_W-1:0] rd_q;

  // ==================================================
  // storage, no reset so the array maps to ram
  always_ff @(posedge clk) begin
    for (int l = 0; l < `LANES; l++) begin
      if (wr.be[l]) begin
        mem[wr.addr][l*`LANE_W +: `LANE_W] <= wr.data[l*`LANE_W +: `LANE_W];
      end
    end
  end

  // ==================================================
  // registered read
  always_comb begin
    rd_d = mem[rd_addr];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_q <= `DATA_RESET;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign rd_data = rd_q;

endmodule

// [core/burst_sram_core.sv]
// Purpose: access control of a pipelined burst SRAM, device side
// Assumes: all pins sampled as synchronous to clk
// Notes: output gate is sampled, so it acts at the next edge
`include "sram_defines.svh"

// Functional notes
// (RQ1) strap: low linear, high interleaved order
// (RQ2) inputs and read data registered on clk
// (RQ3) low address bits load burst counter
// (RQ4) burst step low advances the counter
// (RQ5) strobe, selected, no write starts read
// (RQ6) first select high masks processor strobe
// (RQ7) read data driven next edge when gate low
// (RQ8) emerging from deselect keeps outputs off
// (RQ9) strobe with deselect turns outputs off
// (RQ10) processor start ignores writes and step
// (RQ11) processor write completes on second clock
// (RQ12) global write stores both lanes
// (RQ13) byte write stores selected lanes only
// (RQ14) write cycle turns output drivers off
// (RQ15) far side raises gate before driving; the bench raises it in the same cycle as the write data
// (RQ16) controller strobe write completes one clock
// (RQ17) controller write ignores burst step
// (RQ18) sleep entry and exit take two cycles
// (RQ19) pending accesses dropped entering sleep
// (RQ20) far side deselects before sleep
// (RQ21) far side idles during sleep recovery
// (RQ22) interleaved: start bits xor step count
// (RQ23) linear: low bits plus one, wrapping
// (RQ24) both strobes: processor strobe wins
// (RQ25) processor strobe, selected and not asleep, begins a read
// (RQ26) word is two lanes, own selects
module burst_sram_core (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] data_in,
  input wire sram_pkg::sram_ctrl_t ctl,
  output logic [`DATA_W-1:0] data_out,
  output logic data_oe,
  output logic sleep_active
);
  import sram_pkg::*;

  core_state_t s_q;
  core_state_t s_d;
  logic [`DATA_W-1:0] rd_data;
  logic selected;
  logic psp_ok;
  logic csc_ok;
  logic strobe;
  logic [`LANES-1:0] lanes;
  logic wr_now;
  logic emerge;
  logic desel_now;

  // ==================================================
  // helpers
  function automatic logic [`BURST_W-1:0] next_burst(
    input logic order,
    input logic [`BURST_W-1:0] base,
    input logic [`BURST_W-1:0] step,
    input logic [`BURST_W-1:0] cnt
  );
    logic [`BURST_W-1:0] r;
    if (order == `ORDER_LINEAR) begin
      r = cnt + `STEP_ONE; // RQ23
    end else begin
      r = base ^ (step + `STEP_ONE); // RQ22
    end
    return r;
  endfunction

  function automatic logic [`LANES-1:0] write_lanes(
    input logic gw_n,
    input logic bwe_n,
    input logic [`LANES-1:0] bw_n
  );
    logic [`LANES-1:0] r;
    if (!gw_n) begin
      r = `LANES_ALL; // RQ12
    end else if (!bwe_n) begin
      r = ~bw_n; // RQ13 RQ26
    end else begin
      r = `LANES_NONE;
    end
    return r;
  endfunction

  // ==================================================
  // pin decode
  always_comb begin
    selected = !ctl.chip_select_first_n && ctl.chip_select_second &&
      !ctl.chip_select_third_n;
    psp_ok = !ctl.processor_address_strobe_n && !ctl.chip_select_first_n; // RQ6
    csc_ok = !ctl.controller_address_strobe_n && !psp_ok; // RQ24
    strobe = psp_ok || csc_ok;
    lanes = write_lanes(ctl.global_write_n, ctl.byte_write_enable_n,
      ctl.byte_lane_select_n);
  end

  // ==================================================
  // next state
  always_comb begin
    s_d = s_q;
    wr_now = 1'b0;
    emerge = 1'b0;
    desel_now = 1'b0;
    s_d.wr.be = `LANES_NONE;
    s_d.order = ctl.burst_order; // RQ1
    // first sleep flop feeds only the second
    s_d.sleep_meta = ctl.sleep_request;
    s_d.sleep_sync = s_q.sleep_meta; // RQ18
    if (s_q.sleep_sync) begin
      // pending work is simply dropped
      s_d.mode = ST_SLEEP; // RQ19
    end else if (strobe) begin
      if (!selected) begin
        s_d.mode = ST_DESEL;
        desel_now = 1'b1; // RQ9
      end else begin
        emerge = (s_q.mode != ST_READ) && (s_q.mode != ST_WRITE);
        s_d.addr_hi = addr[`ADDR_W-1:`BURST_W];
        s_d.cnt = addr[`BURST_W-1:0]; // RQ3
        s_d.base = addr[`BURST_W-1:0];
        s_d.step = `BURST_RESET;
        if (csc_ok && (lanes != `LANES_NONE)) begin
          // single cycle write, burst step unused
          s_d.mode = ST_WRITE; // RQ16 RQ17
          wr_now = 1'b1;
          s_d.wr.be = lanes;
          s_d.wr.addr = addr;
          s_d.wr.data = data_in;
        end else begin
          // write controls ignored on this edge
          s_d.mode = ST_READ; // RQ5 RQ10 RQ25
        end
      end
    end else if ((s_q.mode == ST_READ) || (s_q.mode == ST_WRITE)) begin
      if (!ctl.burst_step_n) begin
        s_d.cnt = next_burst(s_q.order, s_q.base, s_q.step, s_q.cnt); // RQ4
        s_d.step = s_q.step + `STEP_ONE;
      end
      if (lanes != `LANES_NONE) begin
        s_d.mode = ST_WRITE; // RQ11
        wr_now = 1'b1;
        s_d.wr.be = lanes;
        s_d.wr.addr = {s_q.addr_hi, s_d.cnt};
        s_d.wr.data = data_in;
      end else begin
        s_d.mode = ST_READ;
      end
    end else if (s_q.mode == ST_SLEEP) begin
      s_d.mode = ST_DESEL;
    end
    // drivers follow the read that was captured one edge ago
    s_d.oe = (s_q.mode == ST_READ) && !ctl.output_gate_n; // RQ7
    // mask must outlive the start edge: data first shows one edge later
    s_d.fresh = emerge;
    if (emerge || s_q.fresh) begin
      s_d.oe = 1'b0; // RQ8
    end
    if (wr_now || desel_now || s_q.sleep_sync) begin
      s_d.oe = 1'b0; // RQ14 RQ9
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.mode <= ST_DESEL;
      s_q.addr_hi <= `HI_RESET;
      s_q.cnt <= `BURST_RESET;
      s_q.base <= `BURST_RESET;
      s_q.step <= `BURST_RESET;
      s_q.order <= `ORDER_RESET;
      s_q.sleep_meta <= 1'b0;
      s_q.sleep_sync <= 1'b0;
      s_q.oe <= 1'b0;
      s_q.fresh <= 1'b0;
      s_q.wr.be <= `LANES_NONE;
      s_q.wr.addr <= `ADDR_RESET;
      s_q.wr.data <= `DATA_RESET;
    end else begin
      s_q <= s_d; // RQ2
    end
  end

  // ==================================================
  // array, its read register is the output register
  sram_word_array u_array (
    .clk(clk),
    .resetn(resetn),
    .rd_addr({s_q.addr_hi, s_q.cnt}),
    .wr(s_q.wr),
    .rd_data(rd_data)
  );

  assign data_out = rd_data; // RQ2
  assign data_oe = s_q.oe;
  assign sleep_active = s_q.sleep_sync;

  // ==================================================
  // checks
  logic run;
  assign run = !s_q.sleep_sync;

  property p_strap_linear;
    @(posedge clk) disable iff (!resetn)
    run && !strobe && (s_q.mode == ST_READ) && !ctl.burst_step_n &&
      (s_q.order == `ORDER_LINEAR) |=> s_q.cnt == $past(s_q.cnt) + `STEP_ONE;
  endproperty
  a_strap_linear: assert property (p_strap_linear) // RQ23
    else $error("linear burst step wrong");

  property p_interleave;
    @(posedge clk) disable iff (!resetn)
    run && !strobe && (s_q.mode == ST_READ) && !ctl.burst_step_n &&
      (s_q.order != `ORDER_LINEAR) |=>
      s_q.cnt == ($past(s_q.base) ^ $past(s_q.step + `STEP_ONE));
  endproperty
  a_interleave: assert property (p_interleave) // RQ22
    else $error("interleaved burst step wrong");

  property p_load;
    @(posedge clk) disable iff (!resetn)
    run && strobe && selected |=> s_q.cnt == $past(addr[`BURST_W-1:0]);
  endproperty
  a_load: assert property (p_load) // RQ3
    else $error("burst counter not loaded");

  property p_psp_masked;
    @(posedge clk) disable iff (!resetn)
    run && !ctl.processor_address_strobe_n && ctl.chip_select_first_n &&
      ctl.controller_address_strobe_n |=>
      (s_q.mode == ST_DESEL) == ($past(s_q.mode) == ST_DESEL);
  endproperty
  a_psp_masked: assert property (p_psp_masked) // RQ6
    else $error("masked processor strobe started access");

  property p_psp_read;
    @(posedge clk) disable iff (!resetn)
    run && psp_ok && selected |=> (s_q.mode == ST_READ) && (s_q.wr.be == `LANES_NONE);
  endproperty
  a_psp_read: assert property (p_psp_read) // RQ25
    else $error("processor strobe did not begin a read");

  property p_csc_write;
    @(posedge clk) disable iff (!resetn)
    run && csc_ok && selected && !ctl.global_write_n |=>
      (s_q.wr.be == `LANES_ALL) && (s_q.wr.addr == $past(addr));
  endproperty
  a_csc_write: assert property (p_csc_write) // RQ16
    else $error("controller write not issued");

  property p_byte_lane;
    @(posedge clk) disable iff (!resetn)
    run && !strobe && (s_q.mode == ST_READ) && ctl.global_write_n &&
      !ctl.byte_write_enable_n |=> s_q.wr.be == ~$past(ctl.byte_lane_select_n);
  endproperty
  a_byte_lane: assert property (p_byte_lane) // RQ13
    else $error("byte lanes wrong");

  property p_write_off;
    @(posedge clk) disable iff (!resetn)
    s_q.wr.be != `LANES_NONE |-> !data_oe;
  endproperty
  a_write_off: assert property (p_write_off) // RQ14
    else $error("driving during write");

  property p_gate;
    @(posedge clk) disable iff (!resetn)
    ctl.output_gate_n |=> !data_oe;
  endproperty
  a_gate: assert property (p_gate) // RQ7
    else $error("driving with gate high");

  property p_desel_off;
    @(posedge clk) disable iff (!resetn)
    strobe && !selected |=> !data_oe && (s_q.mode != ST_READ);
  endproperty
  a_desel_off: assert property (p_desel_off) // RQ9
    else $error("outputs on after deselect");

  property p_emerge_off;
    @(posedge clk) disable iff (!resetn)
    run && strobe && selected && (s_q.mode != ST_READ) && (s_q.mode != ST_WRITE) |=>
      ##1 !data_oe;
  endproperty
  a_emerge_off: assert property (p_emerge_off) // RQ8
    else $error("outputs on in first cycle after deselect");

  property p_sleep_in;
    @(posedge clk) disable iff (!resetn)
    !ctl.sleep_request ##1 ctl.sleep_request [*2] |=> sleep_active && !data_oe;
  endproperty
  a_sleep_in: assert property (p_sleep_in) // RQ18
    else $error("sleep entry not two cycles");

  property p_sleep_out;
    @(posedge clk) disable iff (!resetn)
    ctl.sleep_request ##1 !ctl.sleep_request [*2] |=> !sleep_active;
  endproperty
  a_sleep_out: assert property (p_sleep_out) // RQ18
    else $error("sleep exit not two cycles");

  c_read: cover property (@(posedge clk) disable iff (!resetn)
    psp_ok && selected ##1 1'b1 ##1 data_oe);
  c_csc_write: cover property (@(posedge clk) disable iff (!resetn)
    csc_ok && selected && (lanes != `LANES_NONE));
  c_burst: cover property (@(posedge clk) disable iff (!resetn)
    (s_q.mode == ST_READ) && !strobe && !ctl.burst_step_n [*3]);
  c_sleep: cover property (@(posedge clk) disable iff (!resetn) $rose(sleep_active));

endmodule

// [bench/cache_master.sv]
// Purpose: processor side of the burst SRAM bus
// Assumes: drives only just after a rising clk
// Notes: a write cycle raises the gate; undriven data toggles
`include "sram_defines.svh"

module cache_master (
  input wire logic clk,
  input wire logic strap,
  output logic [`ADDR_W-1:0] addr,
  output logic [`DATA_W-1:0] data_in,
  output sram_pkg::sram_ctrl_t ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_pkg::*;

  // ==================================================
  // idle bus: selected, no strobe, gate on
  function automatic sram_ctrl_t idle();
    idle = '1;
    idle.chip_select_first_n = 1'b0;
    idle.chip_select_third_n = 1'b0;
    idle.output_gate_n = 1'b0;
    idle.sleep_request = 1'b0;
    idle.burst_order = strap;
  endfunction

  initial begin
    ctl = '1;
    addr = '0;
    data_in = '0;
  end

  // ==================================================
  // one bus cycle, launched just after the edge
  task automatic drive(input sram_ctrl_t c, input logic [`ADDR_W-1:0] a,
      input logic [`DATA_W-1:0] d);
    logic wr;
    wr = !c.global_write_n || (!c.byte_write_enable_n && c.byte_lane_select_n != 2'h3);
    @(posedge clk);
    // shared pins: gate raised with the write data; the device turns its drivers off at the next edge
    if (wr) c.output_gate_n = 1'b1;
    ctl <= c;
    addr <= a;
    data_in <= wr ? d : ~data_in;
  endtask
endmodule

// [bench/pipelined_burst_sram_access_bench.sv]
// Purpose: self-checking bench of the burst SRAM core
// Assumes: outputs looked at 1 ns after the edge
// Notes: strap only changed inside reset
`include "sram_defines.svh"

module pipelined_burst_sram_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b1;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] data_in;
  logic [`DATA_W-1:0] data_out;
  sram_ctrl_t ctl;
  logic data_oe;
  logic sleep_active;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;

  always #2.5 clk = ~clk;

  cache_master PEER (.clk(clk), .strap(strap), .addr(addr), .data_in(data_in), .ctl(ctl));
  burst_sram_core DUT (.clk(clk), .resetn(resetn), .addr(addr), .data_in(data_in),
    .ctl(ctl), .data_out(data_out), .data_oe(data_oe), .sleep_active(sleep_active));

  // ==================================================
  // helpers
  task automatic check(input logic [`DATA_W-1:0] seen, input logic [`DATA_W-1:0] exp,
      input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end

  task automatic reboot(input logic o);
    // idle first so a write still pending lands before reset
    PEER.drive(PEER.idle(), '0, '0);
    @(posedge clk);
    resetn <= 1'b0;
    strap <= o;
    repeat (4) @(posedge clk);
    // idle again so the new strap reaches the pins inside reset
    PEER.drive(PEER.idle(), '0, '0);
    #1 check(data_oe, '0, "oe in reset");
    check(sleep_active, '0, "sleep in reset");
    @(posedge clk);
    resetn <= 1'b1;
  endtask

  // lanes_n of zero means a global write
  task automatic cwrite(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d,
      input logic [1:0] lanes_n);
    sram_ctrl_t c;
    c = PEER.idle();
    c.controller_address_strobe_n = 1'b0;
    c.global_write_n = |lanes_n;
    c.byte_write_enable_n = ~|lanes_n;
    c.byte_lane_select_n = lanes_n;
    PEER.drive(c, a, d);
  endtask

  task automatic rd(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] exp);
    sram_ctrl_t c;
    c = PEER.idle();
    c.processor_address_strobe_n = 1'b0;
    PEER.drive(c, a, '0);
    PEER.drive(PEER.idle(), '0, '0);
    PEER.drive(PEER.idle(), '0, '0);
    #1 check(data_out, exp, "read data");
  endtask

  // ==================================================
  // scenarios
  task automatic t_write_read();
    sram_ctrl_t c;
    cwrite(18'h00010, 18'h2a5c3, 2'h0);
    // deselect so the read below emerges from deselect
    c = PEER.idle();
    c.controller_address_strobe_n = 1'b0;
    c.chip_select_first_n = 1'b1;
    PEER.drive(c, '0, '0);
    c = PEER.idle();
    c.processor_address_strobe_n = 1'b0;
    c.controller_address_strobe_n = 1'b0;
    c.global_write_n = 1'b0;
    PEER.drive(c, 18'h00010, 18'h1ffff);
    PEER.drive(PEER.idle(), '0, '0);
    PEER.drive(PEER.idle(), '0, '0);
    #1 check(data_oe, '0, "first cycle oe");
    check(data_out, 18'h2a5c3, "read after write");
    PEER.drive(PEER.idle(), '0, '0);
    #1 check(data_oe, 18'h1, "oe with gate");
    check(data_out, 18'h2a5c3, "no write at start");
    c = PEER.idle();
    c.processor_address_strobe_n = 1'b0;
    c.chip_select_first_n = 1'b1;
    PEER.drive(c, 18'h00033, '0);
    PEER.drive(PEER.idle(), '0, '0);
    #1 check(data_oe, 18'h1, "masked strobe");
    c.processor_address_strobe_n = 1'b1;
    c.controller_address_strobe_n = 1'b0;
    PEER.drive(c, '0, '0);
    PEER.drive(PEER.idle(), '0, '0);
    #1 check(data_oe, '0, "deselect oe");
  endtask

  task automatic t_bytes();
    cwrite(18'h00010, 18'h15555, 2'h2);
    rd(18'h00010, 18'h2a555);
    cwrite(18'h00010, 18'h0aaaa, 2'h1);
    rd(18'h00010, 18'h0ab55);
  endtask

  task automatic t_proc_write();
    sram_ctrl_t c;
    c = PEER.idle();
    c.processor_address_strobe_n = 1'b0;
    c.global_write_n = 1'b0;
    c.burst_step_n = 1'b0;
    PEER.drive(c, 18'h00020, 18'h00001);
    c = PEER.idle();
    c.global_write_n = 1'b0;
    PEER.drive(c, 18'h00030, 18'h3c0f1);
    rd(18'h00020, 18'h3c0f1);
  endtask

  task automatic t_burst(input logic o);
    sram_ctrl_t c;
    sram_ctrl_t s;
    reboot(o);
    s = PEER.idle();
    s.processor_address_strobe_n = 1'b0;
    c = PEER.idle();
    c.burst_step_n = 1'b0;
    PEER.drive(s, 18'h00009, '0);
    PEER.drive(c, '0, '0);
    for (int k = 0; k < 4; k++) begin
      PEER.drive(c, '0, '0);
      #1 check(data_out, 18'(8'h08 + (o ? (k ^ 1) : ((k + 1) & 3))), "burst");
    end
  endtask

  task automatic t_sleep();
    sram_ctrl_t c;
    c = PEER.idle();
    c.controller_address_strobe_n = 1'b0;
    c.chip_select_first_n = 1'b1;
    PEER.drive(c, '0, '0);
    c = PEER.idle();
    c.chip_select_first_n = 1'b1;
    c.sleep_request = 1'b1;
    PEER.drive(c, '0, '0);
    PEER.drive(c, '0, '0);
    #1 check(sleep_active, '0, "sleep entry early");
    PEER.drive(c, '0, '0);
    #1 check(sleep_active, 18'h1, "sleep entered");
    c.sleep_request = 1'b0;
    PEER.drive(c, '0, '0);
    PEER.drive(c, '0, '0);
    #1 check(sleep_active, 18'h1, "sleep exit early");
    PEER.drive(c, '0, '0);
    #1 check(sleep_active, '0, "sleep left");
    check(data_oe, '0, "oe after sleep");
    rd(18'h00020, 18'h3c0f1);
  endtask

  initial begin
    reboot(1'b1);
    t_write_read();
    t_bytes();
    t_proc_write();
    for (int i = 0; i < 4; i++) begin
      cwrite(18'(8'h08 + i), 18'(8'h08 + i), 2'h0);
    end
    t_burst(1'b1);
    t_burst(1'b0);
    t_sleep();
    conclude();
  end
endmodule
